// >>> pkg/fssc_pkg.sv
// Purpose: Shared constants and types for the single-store conversion datapath
// Assumes: Register values are held in 64-bit double format, bit 0 of the
//          format being the most significant bit ([63] here)
// Notes:   Field positions are given in [msb:lsb] vector terms
package fssc_pkg;

    // =====================================================================
    // Widths
    localparam int SRC_W = 64;
    localparam int WORD_W = 32;
    localparam int EXP_W = 11;
    localparam int FRAC_W = 52;
    localparam int SIG_W = 53;
    localparam int UEXP_W = 13;

    // =====================================================================
    // Field positions in the 64-bit source
    localparam int SRC_SIGN_BIT = 63;
    localparam int SRC_EXP_HI = 62;
    localparam int SRC_EXP_LO = 52;
    localparam int SRC_FRAC_HI = 51;
    localparam int SRC_MAG_HI = 62;
    // Direct path: top two bits, then a 30-bit slice
    localparam int DIR_TOP_HI = 63;
    localparam int DIR_TOP_LO = 62;
    localparam int DIR_MID_HI = 58;
    localparam int DIR_MID_LO = 29;
    // Integer word: the low half of the entry
    localparam int INT_WORD_HI = 31;

    // =====================================================================
    // Field positions in the 32-bit store word and the shifted significand
    localparam int WORD_SIGN_BIT = 31;
    localparam int WORD_EXP_HI = 30;
    localparam int WORD_EXP_LO = 23;
    localparam int WORD_FRAC_HI = 22;
    localparam int SIG_TAKE_HI = 51;
    localparam int SIG_TAKE_LO = 29;

    // =====================================================================
    // Exponent thresholds on the unsigned biased field, then the signed bias and unbiased single minimum
    localparam logic [EXP_W-1:0] EXP_DIRECT_ABOVE = 11'h0380;  // 896
    localparam logic [EXP_W-1:0] EXP_DENORM_LOW = 11'h036A;    // 874
    localparam logic signed [UEXP_W-1:0] EXP_BIAS = 13'sh03FF;  // 1023
    localparam logic signed [UEXP_W-1:0] EXP_MIN_SINGLE = -13'sh007E; // -126
    localparam logic [7:0] WORD_EXP_ZERO = 8'h00;

    // =====================================================================
    // Store operation forms
    typedef enum logic [1:0] {
        FSSC_OP_SINGLE,
        FSSC_OP_DOUBLE,
        FSSC_OP_INT_WORD
    } fssc_op_t;

    // Request from the register file side
    typedef struct packed {
        fssc_op_t op;
        logic [SRC_W-1:0] source_fp_register;
    } fssc_req_t;

    // Answer to the store data path; word forms sit in the low 32 bits
    typedef struct packed {
        logic [SRC_W-1:0] data;
        logic is_word;
        logic undefined;
        logic illegal;
    } fssc_rsp_t;

endpackage : fssc_pkg

// >>> verification/fssc_store_convert_tb.sv
// Purpose: Self-checking bench for the single-store conversion datapath
// Assumes: One-cycle answer, no back-pressure, integer-word form present in the main build only
// Notes:   Expected words are queued at issue and popped as the sink takes them, or as the build without the integer-word form answers
`define CHK(nm, ex, got) begin \
    checks_done++; \
    if ((ex) !== (got)) begin \
        fail_count++; \
        $display("CHECK FAILED %s exp=%h got=%h", nm, ex, got); \
    end \
end
module fssc_store_convert_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import fssc_pkg::*;
    // =====================================================================
    // Signals and bookkeeping
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic req_valid = 1'b0;
    fssc_req_t req = '0;
    logic dut_valid;
    fssc_rsp_t dut_rsp;
    logic noint_valid;
    fssc_rsp_t noint_rsp;
    logic took_r;
    fssc_rsp_t took_rsp_r;
    fssc_rsp_t want;
    fssc_rsp_t want_noint;
    fssc_rsp_t exp_q[$];
    fssc_rsp_t noint_q[$];
    int fail_count = 0;
    int checks_done = 0;
    int seed = 54055;
    // Edge exponents around both thresholds, plus NaN and infinity codes
    logic [10:0] ex_tab[9] = '{11'h000, 11'h369, 11'h36A, 11'h36B, 11'h380, 11'h381, 11'h3FF, 11'h7FE, 11'h7FF};
    always #50 clk = ~clk;
    fssc_store_convert dut_u (.clk(clk), .arst_n(arst_n), .req_valid(req_valid), .req(req),
        .rsp_valid_r(dut_valid), .rsp_r(dut_rsp));
    // Second build without the optional integer-word form, fed the same requests
    fssc_store_convert #(.HAS_INT_WORD(1'b0)) dut_noint_u (.clk(clk), .arst_n(arst_n), .req_valid(req_valid),
        .req(req), .rsp_valid_r(noint_valid), .rsp_r(noint_rsp));
    fssc_store_sink sink_u (.clk(clk), .arst_n(arst_n), .rsp_valid_r(dut_valid),
        .rsp_r(dut_rsp), .took_r(took_r), .took_rsp_r(took_rsp_r));
    // =====================================================================
    // Reference conversion, written step by step so it shares nothing with the design
    function automatic fssc_rsp_t expect_of(input fssc_op_t op, input logic [63:0] s, input bit has_int);
        int e;
        logic [52:0] f;
        fssc_rsp_t r;
        e = int'(s[62:52]);
        f = {1'b1, s[51:0]};
        r = '0;
        r.is_word = 1'b1;
        if (op == FSSC_OP_DOUBLE) begin
            r.is_word = 1'b0;
            r.data = s;
        end else if (op == FSSC_OP_INT_WORD && has_int) begin
            r.data = {32'h0000_0000, s[31:0]};
        end else if (op != FSSC_OP_SINGLE) begin
            // Missing option or unused code: refused with an empty word
            r.is_word = (op == FSSC_OP_INT_WORD);
            r.illegal = 1'b1;
        end else if (e > 896 || s[62:0] == 63'h0) begin
            r.data[31:0] = {s[63:62], s[58:29]};
        end else if (e >= 874) begin
            for (e = e - 1023; e < -126; e++) f = f >> 1;
            r.data[31:0] = {s[63], 8'h00, f[51:29]};
        end else begin
            r.undefined = 1'b1;
        end
        return r;
    endfunction : expect_of
    // Issue one request at a clock edge; valid stays up for back-to-back use
    task automatic send(input fssc_op_t op, input logic [63:0] v);
        @(posedge clk);
        req_valid <= 1'b1;
        req <= '{op, v};
        exp_q.push_back(expect_of(op, v, 1'b1));
        noint_q.push_back(expect_of(op, v, 1'b0));
    endtask : send
    task automatic idle();
        @(posedge clk);
        req_valid <= 1'b0;
    endtask : idle
    task automatic report_and_stop();
        $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : report_and_stop
    // =====================================================================
    // Watcher: every word the sink takes must match the oldest note
    always @(posedge clk) begin
        if (took_r) begin
            if (exp_q.size() == 0) begin
                `CHK("spurious answer", 1'b0, 1'b1)
            end else begin
                want = exp_q.pop_front();
                `CHK("store word", want, took_rsp_r)
            end
        end
    end
    // Watcher for the build without the integer-word form, read straight off its outputs
    always @(posedge clk) begin
        if (noint_valid) begin
            if (noint_q.size() == 0) begin
                `CHK("spurious answer no int form", 1'b0, 1'b1)
            end else begin
                want_noint = noint_q.pop_front();
                `CHK("store word no int form", want_noint, noint_rsp)
            end
        end
    end
    // Hang guard
    initial begin
        repeat (5000) @(posedge clk);
        fail_count++;
        report_and_stop();
    end
    // =====================================================================
    // Main sequence: zeros, edge exponents, then a random mix of all three forms
    initial begin
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        send(FSSC_OP_SINGLE, 64'h0000_0000_0000_0000);
        send(FSSC_OP_SINGLE, 64'h8000_0000_0000_0000);
        // Fraction cut to its own 52 bits so sign and exponent survive the concatenation
        foreach (ex_tab[i]) begin
            send(FSSC_OP_SINGLE, {1'b0, ex_tab[i], 52'({$random(seed), $random(seed)})});
            send(FSSC_OP_SINGLE, {1'b1, ex_tab[i], 52'h0_0000_0000_0001});
        end
        idle();
        // Random mix covers all four operation codes, the unused one included
        for (int n = 0; n < 300; n++) begin
            send(fssc_op_t'($random(seed) & 32'h0000_0003), {$random(seed), $random(seed)});
            if ($random(seed) & 1) idle();
        end
        idle();
        for (int n = 0; n < 20 && exp_q.size() != 0; n++) @(posedge clk);
        `CHK("answers outstanding", 0, exp_q.size())
        `CHK("answers outstanding no int form", 0, noint_q.size())
        report_and_stop();
    end
endmodule : fssc_store_convert_tb

// >>> verification/fssc_store_sink.sv
// Purpose: Store data path model that takes converted words toward memory
// Assumes: No back-pressure; every valid answer is accepted in its own cycle
// Notes:   Registers each answer so the bench compares a settled copy
module fssc_store_sink
    import fssc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Answer from the converter
    input wire logic rsp_valid_r,
    input wire fssc_pkg::fssc_rsp_t rsp_r,
    // Captured memory write
    output logic took_r,
    output fssc_pkg::fssc_rsp_t took_rsp_r
);
    timeunit 1ns;
    timeprecision 1ns;

    // =====================================================================
    // Capture; old data kept between writes, as a real write buffer would
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            took_r <= 1'b0;
            took_rsp_r <= '0;
        end else begin
            took_r <= rsp_valid_r;
            if (rsp_valid_r) begin
                took_rsp_r <= rsp_r;
            end
        end
    end
endmodule : fssc_store_sink

// >>> verilog/fssc_store_convert.sv
// Purpose: Converts a register value into the data written by a floating-point store
// Assumes: One request per cycle may be offered; answer follows one clock later
// Notes:   Undefined-range operands yield a zero word with the undefined flag set

module fssc_store_convert #(
    parameter bit HAS_INT_WORD = 1'b1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Request from the register file
    input wire logic req_valid,
    input wire fssc_pkg::fssc_req_t req,
    // Answer to the store data path
    output logic rsp_valid_r,
    output fssc_pkg::fssc_rsp_t rsp_r
);
    import fssc_pkg::*;

    // =====================================================================
    // Source field split
    logic src_sign;
    logic [EXP_W-1:0] src_exp;
    logic [FRAC_W-1:0] src_frac;
    logic mag_zero;
    logic take_direct;
    logic take_denorm;

    // Vector msb is format bit 0; exponent compared unsigned
    assign src_sign = req.source_fp_register[SRC_SIGN_BIT];
    assign src_exp = req.source_fp_register[SRC_EXP_HI:SRC_EXP_LO];
    assign src_frac = req.source_fp_register[SRC_FRAC_HI:0];
    assign mag_zero = (req.source_fp_register[SRC_MAG_HI:0] == '0);

    // Path select; oversized values land on the direct path
    assign take_direct = (src_exp > EXP_DIRECT_ABOVE) || mag_zero;
    assign take_denorm = !take_direct && (src_exp >= EXP_DENORM_LOW);

    // =====================================================================
    // Denormalize path
    logic signed [UEXP_W-1:0] exp_unb;
    logic signed [UEXP_W-1:0] shift_amt;
    logic [SIG_W-1:0] sig;
    logic [SIG_W-1:0] sig_shifted;

    // Unbiased exponent and significand with implicit one
    assign exp_unb = $signed({2'b00, src_exp}) - EXP_BIAS;
    assign sig = {1'b1, src_frac};
    // One barrel shift replaces the one-bit loop: the loop runs exactly
    // (-126 - exp) times, which is 1..23 inside this range
    assign shift_amt = EXP_MIN_SINGLE - exp_unb;
    assign sig_shifted = take_denorm ? (sig >> shift_amt[4:0]) : sig;

    // =====================================================================
    // Word assembly
    logic [WORD_W-1:0] word_direct;
    logic [WORD_W-1:0] word_denorm;
    fssc_rsp_t rsp_nxt;

    // Direct bit selection, no saturation
    assign word_direct = {req.source_fp_register[DIR_TOP_HI:DIR_TOP_LO],
                          req.source_fp_register[DIR_MID_HI:DIR_MID_LO]};
    // Sign, zero exponent, shifted fraction bits 1..23
    assign word_denorm = {src_sign, WORD_EXP_ZERO, sig_shifted[SIG_TAKE_HI:SIG_TAKE_LO]};

    // Form select; integer word absent when the option is off
    always_comb begin
        rsp_nxt = '0;
        unique case (req.op)
            FSSC_OP_SINGLE: begin
                rsp_nxt.is_word = 1'b1;
                if (take_direct) begin
                    rsp_nxt.data = {{WORD_W{1'b0}}, word_direct};
                end else if (take_denorm) begin
                    rsp_nxt.data = {{WORD_W{1'b0}}, word_denorm};
                end else begin
                    rsp_nxt.undefined = 1'b1;
                end
            end
            FSSC_OP_DOUBLE: begin
                rsp_nxt.data = req.source_fp_register;
            end
            FSSC_OP_INT_WORD: begin
                rsp_nxt.is_word = 1'b1;
                if (HAS_INT_WORD) begin
                    rsp_nxt.data = {{WORD_W{1'b0}}, req.source_fp_register[INT_WORD_HI:0]};
                end else begin
                    rsp_nxt.illegal = 1'b1;
                end
            end
            default: begin
                rsp_nxt.illegal = 1'b1;
            end
        endcase
    end

    // =====================================================================
    // Output stage: one register so the store data path sees clean data
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rsp_valid_r <= 1'b0;
        end else begin
            rsp_valid_r <= req_valid;
        end
    end

    // Data held only when a request is taken, so it stays stable otherwise
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rsp_r <= '0;
        end else if (req_valid) begin
            rsp_r <= rsp_nxt;
        end
    end

    // =====================================================================
    // Checks
    sequence single_direct_s;
        req_valid && req.op == FSSC_OP_SINGLE && take_direct;
    endsequence

    sequence single_denorm_s;
        req_valid && req.op == FSSC_OP_SINGLE && take_denorm;
    endsequence

    direct_select_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        single_direct_s |=> rsp_valid_r && rsp_r.data[WORD_W-1:0] ==
            {$past(req.source_fp_register[DIR_TOP_HI:DIR_TOP_LO]),
             $past(req.source_fp_register[DIR_MID_HI:DIR_MID_LO])})
        else $error("direct path word mismatch");

    denorm_range_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        (req_valid && req.op == FSSC_OP_SINGLE && src_exp >= 11'h036A && src_exp <= 11'h0380
         && !mag_zero) |-> take_denorm)
        else $error("denormalize range not taken");

    denorm_shift_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        single_denorm_s |-> shift_amt == 13'sd897 - $signed({2'b00, src_exp}))
        else $error("denormalize shift count wrong");

    denorm_word_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        single_denorm_s |=> rsp_r.data[WORD_SIGN_BIT] == $past(src_sign)
            && rsp_r.data[WORD_EXP_HI:WORD_EXP_LO] == 8'h00 && !rsp_r.undefined)
        else $error("denormal word fields wrong");

    undef_flag_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        (req_valid && req.op == FSSC_OP_SINGLE && !mag_zero && src_exp < 11'h036A)
        |=> rsp_r.undefined)
        else $error("undefined range not flagged");

    no_saturate_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        (req_valid && req.op == FSSC_OP_SINGLE && src_exp > 11'h047E && src_exp != 11'h07FF)
        |=> rsp_r.data[WORD_EXP_HI:WORD_EXP_LO] != 8'hFF || $past(src_exp[6:0]) == 7'h7F)
        else $error("oversized value saturated");

    double_pass_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        (req_valid && req.op == FSSC_OP_DOUBLE) |=> rsp_valid_r
            && rsp_r.data == $past(req.source_fp_register) && !rsp_r.is_word)
        else $error("double store altered data");

    int_word_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        (req_valid && req.op == FSSC_OP_INT_WORD) |=> rsp_r.illegal == !HAS_INT_WORD)
        else $error("integer word option handling wrong");

    hold_idle_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        !req_valid |=> !rsp_valid_r && $stable(rsp_r))
        else $error("answer changed without a request");

endmodule : fssc_store_convert
